// File: design/afsl_alert_fault.v
// Notes on behaviour
// - Alert simulation can only be enabled while the jumper is installed.
// - While simulation is enabled, host writes to the alert flags apply.
// - Alert simulation enable is clear after every power-up reset.
// - Simulation enable clears on host clear or on jumper removal.
// - Simulated fail, maintenance or advisory flags make that class active.
// - With status option set, alert classes set the process value status.
// - With fault reporting, output fault bits mirror the transducer fault bits.
// - With fault reporting, output fault bit 6 shows any maintenance alert.
// - With fault reporting, output fault bit 13 shows any failed alert.
// - Fault bit 1 shows any configuration value out of range.
// - Fault bit 3 shows the simulation jumper installed.
// - Fault bit 10 shows incomplete factory characterization.
// - Fault bit 13 also shows incomplete factory characterization.
// - Fault bit 15 shows the actual mode out of service, else clear.
// - Transducer fault bits 0,2,4-9,11,12 and 14 are never set.
//
// The implementer's own choices: strobed register access and the address map.
`timescale 1ns/1ps
`include "afsl_map.vh"
module afsl_alert_fault (
  // Clock and reset
  input wire ref_clk,
  input wire rst_n,
  // Register port
  input wire [3:0] regAddr,
  input wire [15:0] regWrData,
  input wire regWrEn,
  input wire regRdEn,
  output reg [15:0] regRdData,
  // Device conditions
  input wire simJumper,
  input wire cfgRangeError,
  input wire charIncomplete,
  input wire modeOutOfService,
  input wire modeManual,
  input wire [14:0] liveAlerts,
  // Status outputs
  output reg [15:0] transducerFaultBits,
  output reg [15:0] outputFaultBits,
  output reg [1:0] processValueStatus,
  output reg alertSimEnable
);

  // ----------------------------------------------------------------
  // Control and simulated alert state
  // ----------------------------------------------------------------
  reg [2:0] ctrl_reg;
  reg [2:0] ctrl_next;
  reg [14:0] simAlert_reg;
  reg [14:0] simAlert_next;
  wire wrCtrl;
  wire wrAlert;
  wire [14:0] activeAlerts;
  wire failActive;
  wire maintActive;
  wire advActive;
  reg [15:0] fault_next;
  reg [15:0] outFault_next;
  reg [1:0] pv_next;
  reg [15:0] rd_next;

  assign wrCtrl = regWrEn && (regAddr == `AFSL_ADDR_CTRL);
  assign wrAlert = regWrEn && (regAddr == `AFSL_ADDR_ALERT);

  always @* begin
    ctrl_next = ctrl_reg;
    if (wrCtrl) begin
      ctrl_next[`AFSL_CTRL_PVSET] = regWrData[`AFSL_CTRL_PVSET];
      ctrl_next[`AFSL_CTRL_FREP] = regWrData[`AFSL_CTRL_FREP];
      ctrl_next[`AFSL_CTRL_SIM] = regWrData[`AFSL_CTRL_SIM] & simJumper;
    end
    if (!simJumper) begin
      ctrl_next[`AFSL_CTRL_SIM] = 1'b0;
    end
  end

  always @* begin
    simAlert_next = simAlert_reg;
    if (wrAlert && ctrl_reg[`AFSL_CTRL_SIM]) begin
      simAlert_next = regWrData[14:0];
    end
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= `AFSL_RST_CTRL;
      simAlert_reg <= `AFSL_RST_ALERT;
    end else begin
      ctrl_reg <= ctrl_next;
      simAlert_reg <= simAlert_next;
    end
  end

  // ----------------------------------------------------------------
  // Active alert classes
  // ----------------------------------------------------------------
  assign activeAlerts = ctrl_reg[`AFSL_CTRL_SIM] ? simAlert_reg :
                        liveAlerts;
  assign failActive = activeAlerts[`AFSL_AL_FAIL];
  assign maintActive = activeAlerts[`AFSL_AL_MAINT];
  assign advActive = activeAlerts[`AFSL_AL_ADV];

  // ----------------------------------------------------------------
  // Fault bit strings
  // ----------------------------------------------------------------
  always @* begin
    fault_next = 16'h0000;
    fault_next[`AFSL_FB_CFG] = cfgRangeError;
    fault_next[`AFSL_FB_SIMJ] = simJumper;
    fault_next[`AFSL_FB_LOST] = charIncomplete;
    fault_next[`AFSL_FB_MNOW] = charIncomplete;
    fault_next[`AFSL_FB_OOS] = modeOutOfService;
  end

  always @* begin
    outFault_next = 16'h0000;
    if (ctrl_reg[`AFSL_CTRL_FREP]) begin
      outFault_next = fault_next;
      outFault_next[`AFSL_FB_MSOON] = maintActive;
      outFault_next[`AFSL_FB_MNOW] = failActive | charIncomplete;
    end
  end

  // ----------------------------------------------------------------
  // Process value status
  // ----------------------------------------------------------------
  always @* begin
    if (modeOutOfService || modeManual) begin
      pv_next = `AFSL_PV_BAD;
    end else if (!ctrl_reg[`AFSL_CTRL_PVSET]) begin
      pv_next = `AFSL_PV_GOOD;
    end else if (failActive || maintActive) begin
      pv_next = `AFSL_PV_UNCERTAIN;
    end else if (advActive) begin
      pv_next = `AFSL_PV_ADVISORY;
    end else begin
      pv_next = `AFSL_PV_GOOD;
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always @* begin
    case (regAddr)
      `AFSL_ADDR_FAULT: rd_next = fault_next;
      `AFSL_ADDR_CTRL: rd_next = {13'h0000, ctrl_reg};
      `AFSL_ADDR_ALERT: rd_next = {1'b0, activeAlerts};
      `AFSL_ADDR_OUTFAULT: rd_next = outFault_next;
      `AFSL_ADDR_PVSTAT: rd_next = {14'h0000, pv_next};
      default: rd_next = 16'h0000;
    endcase
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdData <= 16'h0000;
      transducerFaultBits <= 16'h0000;
      outputFaultBits <= 16'h0000;
      processValueStatus <= `AFSL_PV_BAD;
      alertSimEnable <= 1'b0;
    end else begin
      regRdData <= regRdEn ? rd_next : 16'h0000;
      transducerFaultBits <= fault_next;
      outputFaultBits <= outFault_next;
      processValueStatus <= pv_next;
      alertSimEnable <= ctrl_next[`AFSL_CTRL_SIM];
    end
  end

endmodule // afsl_alert_fault

// File: design/afsl_map.vh
`ifndef AFSL_MAP_VH
`define AFSL_MAP_VH
// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define AFSL_ADDR_FAULT 4'h0
`define AFSL_ADDR_CTRL 4'h1
`define AFSL_ADDR_ALERT 4'h2
`define AFSL_ADDR_OUTFAULT 4'h3
`define AFSL_ADDR_PVSTAT 4'h4
`define AFSL_ADDR_COND 4'h5
// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define AFSL_CTRL_SIM 0
`define AFSL_CTRL_PVSET 1
`define AFSL_CTRL_FREP 2
// ----------------------------------------------------------------
// Alert flag fields
// ----------------------------------------------------------------
`define AFSL_AL_FAIL 0
`define AFSL_AL_MAINT 1
`define AFSL_AL_ADV 2
`define AFSL_AL_WIDTH 15
// ----------------------------------------------------------------
// Fault bit positions
// ----------------------------------------------------------------
`define AFSL_FB_CFG 1
`define AFSL_FB_SIMJ 3
`define AFSL_FB_MSOON 6
`define AFSL_FB_LOST 10
`define AFSL_FB_MNOW 13
`define AFSL_FB_OOS 15
// ----------------------------------------------------------------
// Process value status codes
// ----------------------------------------------------------------
`define AFSL_PV_GOOD 2'h0
`define AFSL_PV_ADVISORY 2'h1
`define AFSL_PV_UNCERTAIN 2'h2
`define AFSL_PV_BAD 2'h3
// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define AFSL_RST_CTRL 3'h0
`define AFSL_RST_ALERT 15'h0000
`endif

// File: verification/afsl_checker_properties.sv
`timescale 1ns/1ps
module afsl_checker (
  // Watched ports
  input wire ref_clk,
  input wire rst_n,
  input wire regRdEn,
  input wire [15:0] regRdData,
  input wire simJumper,
  input wire charIncomplete,
  input wire modeOutOfService,
  input wire [15:0] transducerFaultBits,
  input wire [15:0] outputFaultBits,
  input wire alertSimEnable
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  property p_jmp; rst_n |=> transducerFaultBits[3] == $past(simJumper);
  endproperty
  a_jmp: assert property (p_jmp) else $error("jumper bit");
  property p_chr; rst_n |=> transducerFaultBits[13] == $past(charIncomplete)
    && transducerFaultBits[10] == $past(charIncomplete); endproperty
  a_chr: assert property (p_chr) else $error("char bits");
  property p_oos; rst_n |=> transducerFaultBits[15] == $past(modeOutOfService);
  endproperty
  a_oos: assert property (p_oos) else $error("oos bit");
  property p_na; (transducerFaultBits & 16'h5BF5) == 16'h0000; endproperty
  a_na: assert property (p_na) else $error("unused bit set");
  property p_sim; !simJumper |=> !alertSimEnable; endproperty
  a_sim: assert property (p_sim) else $error("sim kept");
  property p_pwr; disable iff (1'b0) !rst_n ##1 !rst_n |-> !alertSimEnable;
  endproperty
  a_pwr: assert property (p_pwr) else $error("sim in reset");
  property p_mir; outputFaultBits != 16'h0000 |->
    (outputFaultBits | 16'h2040) == (transducerFaultBits | 16'h2040);
  endproperty
  a_mir: assert property (p_mir) else $error("mirror");
  property p_rd; !regRdEn |=> regRdData == 16'h0000; endproperty
  a_rd: assert property (p_rd) else $error("stray data");
  c_sim: cover property (alertSimEnable ##1 !alertSimEnable);
  c_mnt: cover property (outputFaultBits[6]);
  c_oos: cover property (transducerFaultBits[15]);
endmodule // afsl_checker
bind afsl_alert_fault afsl_checker i_chk (.*);

// File: verification/afsl_host_model.sv
`timescale 1ns/1ps
module afsl_host_model (
  // Register port
  input wire ref_clk,
  output reg [3:0] regAddr,
  output reg [15:0] regWrData,
  output reg regWrEn,
  output reg regRdEn,
  input wire [15:0] regRdData
);
  initial {regAddr, regWrData, regWrEn, regRdEn} = 22'h0;
  task wr(input [3:0] a, input [15:0] d);
    @(posedge ref_clk);
    {regAddr, regWrData, regWrEn} <= {a, d, 1'b1};
    @(posedge ref_clk);
    {regWrData, regWrEn} <= {~d, 1'b0};
  endtask
  task rd(input [3:0] a, output [15:0] d);
    @(posedge ref_clk);
    {regAddr, regRdEn} <= {a, 1'b1};
    @(posedge ref_clk);
    regRdEn <= 1'b0;
    @(negedge ref_clk);
    d = regRdData;
  endtask
endmodule // afsl_host_model

// File: verification/afsl_tb.sv
`timescale 1ns/1ps
module tb;
  // Stimulus and observed signals
  reg ref_clk = 0, rst_n = 0, simJumper = 0, cfgRangeError = 0;
  reg charIncomplete = 0, modeOutOfService = 0, modeManual = 0;
  reg [14:0] liveAlerts = 15'h0;
  wire [15:0] regWrData, regRdData, transducerFaultBits, outputFaultBits;
  wire [3:0] regAddr;
  wire [1:0] processValueStatus;
  wire regWrEn, regRdEn, alertSimEnable;
  integer bad_count = 0, num_checks = 0, cyc = 0;
  reg [15:0] rv;
  afsl_alert_fault i_afsl_alert_fault (.*);
  afsl_host_model i_afsl_host_model (.*);
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      bad_count = bad_count + 1;
      complete_run;
    end
  end
  task complete_run;
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input [15:0] got, input [15:0] exp);
    num_checks = num_checks + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task r(input [3:0] a, input [15:0] exp);
    i_afsl_host_model.rd(a, rv);
    chk(rv, exp);
  endtask
  task w(input [3:0] a, input [15:0] d); i_afsl_host_model.wr(a, d); endtask
  task cond(input [3:0] c);
    @(posedge ref_clk);
    {cfgRangeError, simJumper, charIncomplete, modeOutOfService} <= c;
    repeat (2) @(posedge ref_clk);
  endtask
  task t_fault;
    cond(4'hF);
    chk(transducerFaultBits, 16'hA40A);
    r(4'h0, 16'hA40A);
    r(4'h4, 16'h0003);
    chk({14'h0, processValueStatus}, 16'h0003);
    cond(4'h0);
    chk(transducerFaultBits, 16'h0000);
  endtask
  task t_sim;
    liveAlerts <= 15'h0004;
    r(4'h2, 16'h0004);
    w(4'h1, 16'h0001);
    r(4'h1, 16'h0000);
    cond(4'h4);
    w(4'h1, 16'h0007);
    w(4'h2, 16'h0003);
    r(4'h3, 16'h2048);
    chk(outputFaultBits, 16'h2048);
    r(4'h4, 16'h0002);
    w(4'h2, 16'h0004);
    r(4'h4, 16'h0001);
    w(4'h1, 16'h0003);
    r(4'h3, 16'h0000);
    w(4'h1, 16'h0001);
    r(4'h4, 16'h0000);
    r(4'hF, 16'h0000);
    cond(4'h0);
    chk({15'h0, alertSimEnable}, 16'h0000);
  endtask
  task t_pwr;
    cond(4'h4);
    w(4'h1, 16'h0001);
    r(4'h1, 16'h0001);
    w(4'h1, 16'h0000);
    r(4'h1, 16'h0000);
    w(4'h1, 16'h0001);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk({15'h0, alertSimEnable}, 16'h0000);
    rst_n <= 1'b1;
    r(4'h1, 16'h0000);
  endtask
  initial begin
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_fault;
    t_sim;
    t_pwr;
    complete_run;
  end
endmodule // tb
